// ===== rtl/uart_sleep_wake_loopback.sv
// UART core with special-character detect, auto sleep, charge-pump control and internal loopback
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module uart_sleep_wake_loopback #(
  parameter int PUMP_IDLE_CYCLES = uart_sleep_pkg::PUMP_IDLE_CYC
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Serial line
  input  wire logic        i_serial_in,
  output logic             o_serial_out,
  output logic             o_serial_out_oe,
  // Modem pins
  input  wire logic        i_clear_to_send_in,
  input  wire logic        i_set_ready_in,
  input  wire logic        i_line_presence_in,
  input  wire logic        i_bell_in,
  output logic             o_request_to_send_out,
  output logic             o_terminal_ready_out,
  output logic             o_modem_out_oe,
  // Power control
  input  wire logic        i_pump_autosleep_pin,
  output logic             o_osc_run,
  output logic             o_pump_on,
  output logic             o_pump_ready
);

  typedef enum logic {ST_AWAKE, ST_ASLEEP} sleep_state_e;
  typedef enum logic [1:0] {PUMP_ON, PUMP_OFF, PUMP_START} pump_state_e;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] word_mask(input logic [1:0] wl);
    case (wl)
      2'h0:    word_mask = 8'h1F;
      2'h1:    word_mask = 8'h3F;
      2'h2:    word_mask = 8'h7F;
      default: word_mask = 8'hFF;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0]   ier_reg, lcr_reg, mcr_reg, dll_reg, dlm_reg, efr_reg, spc_reg;
  logic [5:0]   sync1_reg, sync2_reg;
  logic [3:0]   modem_prev_reg, delta_reg;
  logic         special_reg;
  sleep_state_e sleep_reg;
  pump_state_e  pump_reg;
  logic         off_by_full_reg;
  logic [31:0]  idle_cnt_reg;
  logic [10:0]  start_cnt_reg;
  logic [15:0]  div_cnt_reg;
  logic         tick_reg;
  logic         tx_pend_reg, tx_busy_reg, tx_line_reg;
  logic [7:0]   tx_buf_reg, tx_shift_reg;
  logic [3:0]   tx_bits_reg, tx_cnt_reg;
  logic         rx_prev_reg, rx_busy_reg, rx_ready_reg;
  logic [3:0]   rx_idx_reg, rx_cnt_reg;
  logic [7:0]   rx_shift_reg, rx_data_reg;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sync1_reg <= 6'h3F;
      sync2_reg <= 6'h3F;
    end else begin
      sync1_reg <= {i_pump_autosleep_pin, i_bell_in, i_line_presence_in,
                    i_set_ready_in, i_clear_to_send_in, i_serial_in};
      sync2_reg <= sync1_reg;
    end
  end

  logic       loop, pump_pin, rx_in, apb_done, wr, rd, pend, tx_load;
  logic [3:0] modem_eff, modem_chg, modem_rise;
  logic [3:0] n_data;
  logic [7:0] mask, rx_aligned;

  assign loop     = mcr_reg[uart_sleep_pkg::MCR_LOOP_BIT];
  assign pump_pin = sync2_reg[5];
  assign rx_in    = loop ? tx_line_reg : sync2_reg[0];
  assign mask     = word_mask(lcr_reg[1:0]);
  assign n_data   = 4'h5 + {2'b00, lcr_reg[1:0]};

  // Loopback feeds modem control bits back as the inputs; the pins are ignored
  assign modem_eff = loop ? ~{mcr_reg[uart_sleep_pkg::MCR_OUT2_BIT], mcr_reg[uart_sleep_pkg::MCR_OUT1_BIT],
                              mcr_reg[uart_sleep_pkg::MCR_DTR_BIT], mcr_reg[uart_sleep_pkg::MCR_RTS_BIT]}
                          : sync2_reg[4:1];
  assign modem_chg  = modem_eff ^ modem_prev_reg;
  assign modem_rise = modem_eff & ~modem_prev_reg;

  // ---------------------------------------------------------------
  // APB slave, one wait-free access phase; registers always reachable
  // ---------------------------------------------------------------
  assign apb_done = i_psel && i_penable && o_pready;
  assign wr       = apb_done && i_pwrite;
  assign rd       = apb_done && !i_pwrite;
  assign tx_load  = wr && (i_paddr == uart_sleep_pkg::ADDR_TX_HOLDING);

  logic [7:0] rd_mux;
  logic       rd_err;
  always_comb begin
    rd_mux = 8'h00;
    rd_err = 1'b0;
    case (i_paddr)
      uart_sleep_pkg::ADDR_TX_HOLDING:   rd_mux = rx_data_reg;
      uart_sleep_pkg::ADDR_INT_ENABLE:   rd_mux = ier_reg;
      uart_sleep_pkg::ADDR_INT_SOURCE: begin
        rd_mux[uart_sleep_pkg::ISR_SPECIAL_BIT] = special_reg;
        rd_mux[uart_sleep_pkg::ISR_NONE_BIT]    = !pend;
      end
      uart_sleep_pkg::ADDR_LINE_CTRL:    rd_mux = lcr_reg;
      uart_sleep_pkg::ADDR_MODEM_CTRL:   rd_mux = mcr_reg;
      uart_sleep_pkg::ADDR_MODEM_STATUS: rd_mux = {~modem_eff, delta_reg};
      uart_sleep_pkg::ADDR_DIV_LOW:      rd_mux = dll_reg;
      uart_sleep_pkg::ADDR_DIV_HIGH:     rd_mux = dlm_reg;
      uart_sleep_pkg::ADDR_ENH_FEATURE:  rd_mux = efr_reg;
      uart_sleep_pkg::ADDR_SPECIAL_CHAR: rd_mux = spc_reg;
      uart_sleep_pkg::ADDR_POWER_STATUS: begin
        rd_mux[uart_sleep_pkg::PWR_ASLEEP_BIT]     = (sleep_reg == ST_ASLEEP);
        rd_mux[uart_sleep_pkg::PWR_PUMP_OFF_BIT]   = (pump_reg == PUMP_OFF);
        rd_mux[uart_sleep_pkg::PWR_FULL_BIT]       = (sleep_reg == ST_ASLEEP) && (pump_reg == PUMP_OFF);
        rd_mux[uart_sleep_pkg::PWR_PUMP_READY_BIT] = (pump_reg == PUMP_ON);
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_psel && !i_penable) begin
      o_pready  <= 1'b1;
      o_prdata  <= i_pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      o_pslverr <= rd_err;
    end else if (apb_done) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ier_reg <= uart_sleep_pkg::IER_RST;
      lcr_reg <= uart_sleep_pkg::LCR_RST;
      mcr_reg <= uart_sleep_pkg::MCR_RST;
      dll_reg <= uart_sleep_pkg::DLL_RST;
      dlm_reg <= uart_sleep_pkg::DLM_RST;
      efr_reg <= uart_sleep_pkg::EFR_RST;
      spc_reg <= uart_sleep_pkg::SPC_RST;
    end else if (wr) begin
      case (i_paddr)
        uart_sleep_pkg::ADDR_INT_ENABLE:   ier_reg <= i_pwdata[7:0];
        uart_sleep_pkg::ADDR_LINE_CTRL:    lcr_reg <= i_pwdata[7:0];
        uart_sleep_pkg::ADDR_MODEM_CTRL:   mcr_reg <= i_pwdata[7:0];
        uart_sleep_pkg::ADDR_DIV_LOW:      dll_reg <= i_pwdata[7:0];
        uart_sleep_pkg::ADDR_DIV_HIGH:     dlm_reg <= i_pwdata[7:0];
        uart_sleep_pkg::ADDR_ENH_FEATURE:  efr_reg <= i_pwdata[7:0];
        uart_sleep_pkg::ADDR_SPECIAL_CHAR: spc_reg <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Modem status deltas; set wins over the clearing read
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      modem_prev_reg <= 4'hF;
      delta_reg      <= 4'h0;
    end else begin
      modem_prev_reg <= modem_eff;
      if (rd && (i_paddr == uart_sleep_pkg::ADDR_MODEM_STATUS)) begin
        delta_reg <= modem_chg;
      end else begin
        delta_reg <= delta_reg | modem_chg;
      end
    end
  end

  assign pend = (ier_reg[uart_sleep_pkg::IER_RX_DATA_BIT] && rx_ready_reg) ||
                (ier_reg[uart_sleep_pkg::IER_MODEM_BIT] && (delta_reg != 4'h0)) ||
                special_reg;

  // ---------------------------------------------------------------
  // Sleep controller
  // ---------------------------------------------------------------
  logic rx_start_edge, wake, can_sleep;
  assign rx_start_edge = rx_prev_reg && !rx_in;
  assign wake          = rx_start_edge || tx_load || (modem_chg != 4'h0);
  assign can_sleep     = !pend && ({dlm_reg, dll_reg} != 16'h0000) &&
                         ier_reg[uart_sleep_pkg::IER_SLEEP_BIT] && (delta_reg == 4'h0) &&
                         rx_in && !rx_busy_reg && !tx_busy_reg && !tx_pend_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sleep_reg <= ST_AWAKE;
    end else begin
      case (sleep_reg)
        ST_AWAKE: begin
          if (can_sleep && !wake) begin
            sleep_reg <= ST_ASLEEP;
          end
        end
        ST_ASLEEP: begin
          if (wake || !ier_reg[uart_sleep_pkg::IER_SLEEP_BIT]) begin
            sleep_reg <= ST_AWAKE;
          end
        end
        default: sleep_reg <= ST_AWAKE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Charge pump controller
  // ---------------------------------------------------------------
  logic line_idle, pump_wake;
  assign line_idle = !tx_busy_reg && !tx_pend_reg && (modem_eff == 4'h0) && (modem_chg == 4'h0);
  assign pump_wake = rx_start_edge || tx_load || (modem_rise != 4'h0);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      idle_cnt_reg <= 32'h0000_0000;
    end else if (!pump_pin || !line_idle || sleep_reg == ST_ASLEEP || pump_reg != PUMP_ON) begin
      idle_cnt_reg <= 32'h0000_0000;
    end else if (idle_cnt_reg < 32'(PUMP_IDLE_CYCLES)) begin
      idle_cnt_reg <= idle_cnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pump_reg        <= PUMP_ON;
      off_by_full_reg <= 1'b0;
      start_cnt_reg   <= 11'h000;
    end else begin
      case (pump_reg)
        PUMP_ON: begin
          if (pump_pin && sleep_reg == ST_ASLEEP) begin
            pump_reg        <= PUMP_OFF;
            off_by_full_reg <= 1'b1;
          end else if (pump_pin && idle_cnt_reg >= 32'(PUMP_IDLE_CYCLES)) begin
            pump_reg        <= PUMP_OFF;
            off_by_full_reg <= 1'b0;
          end
        end
        PUMP_OFF: begin
          if (!pump_pin || pump_wake || (off_by_full_reg && sleep_reg == ST_AWAKE)) begin
            pump_reg      <= PUMP_START;
            start_cnt_reg <= 11'h000;
          end
        end
        PUMP_START: begin
          if (start_cnt_reg >= 11'(uart_sleep_pkg::PUMP_START_CYC - 1)) begin
            pump_reg <= PUMP_ON;
          end else begin
            start_cnt_reg <= start_cnt_reg + 11'h001;
          end
        end
        default: pump_reg <= PUMP_ON;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Baud tick at sixteen times the bit rate, stopped while asleep
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b0;
    end else if (sleep_reg == ST_ASLEEP || {dlm_reg, dll_reg} == 16'h0000) begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b0;
    end else if (div_cnt_reg >= {dlm_reg, dll_reg} - 16'h0001) begin
      div_cnt_reg <= 16'h0000;
      tick_reg    <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
      tick_reg    <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Transmitter: holding byte and shift register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tx_pend_reg  <= 1'b0;
      tx_buf_reg   <= 8'h00;
      tx_busy_reg  <= 1'b0;
      tx_line_reg  <= 1'b1;
      tx_shift_reg <= 8'hFF;
      tx_bits_reg  <= 4'h0;
      tx_cnt_reg   <= 4'h0;
    end else begin
      if (tx_load) begin
        tx_pend_reg <= 1'b1;
        tx_buf_reg  <= i_pwdata[7:0];
      end else if (!tx_busy_reg && tx_pend_reg && tick_reg) begin
        tx_pend_reg <= 1'b0;
      end
      if (!tx_busy_reg && tx_pend_reg && tick_reg) begin
        tx_busy_reg  <= 1'b1;
        tx_line_reg  <= 1'b0;
        tx_shift_reg <= tx_buf_reg | ~mask;
        tx_bits_reg  <= n_data + 4'h1;
        tx_cnt_reg   <= 4'h0;
      end else if (tx_busy_reg && tick_reg) begin
        tx_cnt_reg <= tx_cnt_reg + 4'h1;
        if (tx_cnt_reg == uart_sleep_pkg::LAST_BIT_TICK) begin
          if (tx_bits_reg == 4'h0) begin
            tx_busy_reg <= 1'b0;
            tx_line_reg <= 1'b1;
          end else begin
            tx_line_reg  <= tx_shift_reg[0];
            tx_shift_reg <= {1'b1, tx_shift_reg[7:1]};
            tx_bits_reg  <= tx_bits_reg - 4'h1;
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Receiver with special-character compare
  // ---------------------------------------------------------------
  assign rx_aligned = rx_shift_reg >> (3'h3 - {1'b0, lcr_reg[1:0]});

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_prev_reg  <= 1'b1;
      rx_busy_reg  <= 1'b0;
      rx_idx_reg   <= 4'h0;
      rx_cnt_reg   <= 4'h0;
      rx_shift_reg <= 8'h00;
    end else begin
      rx_prev_reg <= rx_in;
      if (!rx_busy_reg && rx_start_edge && sleep_reg == ST_AWAKE) begin
        rx_busy_reg <= 1'b1;
        rx_idx_reg  <= 4'h0;
        rx_cnt_reg  <= uart_sleep_pkg::HALF_BIT_TICKS;
      end else if (rx_busy_reg && tick_reg) begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
        if (rx_cnt_reg == uart_sleep_pkg::LAST_BIT_TICK) begin
          if (rx_idx_reg == 4'h0 && rx_in) begin
            rx_busy_reg <= 1'b0;
          end else if (rx_idx_reg <= n_data) begin
            if (rx_idx_reg != 4'h0) begin
              rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
            end
            rx_idx_reg <= rx_idx_reg + 4'h1;
          end else begin
            rx_busy_reg <= 1'b0;
          end
        end
      end
    end
  end

  logic rx_done, rx_match;
  assign rx_done  = rx_busy_reg && tick_reg && rx_cnt_reg == uart_sleep_pkg::LAST_BIT_TICK &&
                    rx_idx_reg > n_data;
  assign rx_match = efr_reg[uart_sleep_pkg::EFR_SPECIAL_EN_BIT] &&
                    (((rx_aligned ^ spc_reg) & mask) == 8'h00);

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_data_reg  <= 8'h00;
      rx_ready_reg <= 1'b0;
    end else if (rx_done) begin
      rx_data_reg  <= rx_aligned;
      rx_ready_reg <= 1'b1;
    end else if (rd && i_paddr == uart_sleep_pkg::ADDR_TX_HOLDING) begin
      rx_ready_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      special_reg <= 1'b0;
    end else if (rx_done && rx_match) begin
      special_reg <= 1'b1;
    end else if (rd && i_paddr == uart_sleep_pkg::ADDR_INT_SOURCE) begin
      special_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Pin and power outputs
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_serial_out          <= 1'b1;
      o_serial_out_oe       <= 1'b1;
      o_request_to_send_out <= 1'b1;
      o_terminal_ready_out  <= 1'b1;
      o_modem_out_oe        <= 1'b1;
      o_osc_run             <= 1'b1;
      o_pump_on             <= 1'b1;
      o_pump_ready          <= 1'b1;
    end else begin
      o_serial_out          <= loop ? 1'b1 : tx_line_reg;
      o_request_to_send_out <= loop ? 1'b1 : !mcr_reg[uart_sleep_pkg::MCR_RTS_BIT];
      o_terminal_ready_out  <= loop ? 1'b1 : !mcr_reg[uart_sleep_pkg::MCR_DTR_BIT];
      o_serial_out_oe       <= (pump_reg != PUMP_OFF);
      o_modem_out_oe        <= (pump_reg != PUMP_OFF);
      o_osc_run             <= (sleep_reg == ST_AWAKE);
      o_pump_on             <= (pump_reg != PUMP_OFF);
      o_pump_ready          <= (pump_reg == PUMP_ON);
    end
  end

endmodule

// ===== rtl/uart_sleep_pkg.sv
// Constants for the sleep, wake-up, special-character and loopback logic of the UART core
package uart_sleep_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TX_HOLDING   = 8'h00;
  localparam logic [7:0] ADDR_INT_ENABLE   = 8'h04;
  localparam logic [7:0] ADDR_INT_SOURCE   = 8'h08;
  localparam logic [7:0] ADDR_LINE_CTRL    = 8'h0C;
  localparam logic [7:0] ADDR_MODEM_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_MODEM_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DIV_LOW      = 8'h18;
  localparam logic [7:0] ADDR_DIV_HIGH     = 8'h1C;
  localparam logic [7:0] ADDR_ENH_FEATURE  = 8'h20;
  localparam logic [7:0] ADDR_SPECIAL_CHAR = 8'h24;
  localparam logic [7:0] ADDR_POWER_STATUS = 8'h28;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int IER_RX_DATA_BIT    = 0;
  localparam int IER_MODEM_BIT      = 3;
  localparam int IER_SLEEP_BIT      = 4;
  localparam int ISR_NONE_BIT       = 0;
  localparam int ISR_SPECIAL_BIT    = 4;
  localparam int EFR_SPECIAL_EN_BIT = 5;
  localparam int MCR_DTR_BIT        = 0;
  localparam int MCR_RTS_BIT        = 1;
  localparam int MCR_OUT1_BIT       = 2;
  localparam int MCR_OUT2_BIT       = 3;
  localparam int MCR_LOOP_BIT       = 4;
  localparam int PWR_ASLEEP_BIT     = 0;
  localparam int PWR_PUMP_OFF_BIT   = 1;
  localparam int PWR_FULL_BIT       = 2;
  localparam int PWR_PUMP_READY_BIT = 3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IER_RST = 8'h00;
  localparam logic [7:0] LCR_RST = 8'h03;
  localparam logic [7:0] MCR_RST = 8'h00;
  localparam logic [7:0] DLL_RST = 8'h01;
  localparam logic [7:0] DLM_RST = 8'h00;
  localparam logic [7:0] EFR_RST = 8'h00;
  localparam logic [7:0] SPC_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [3:0] HALF_BIT_TICKS  = 4'h8;
  localparam logic [3:0] LAST_BIT_TICK   = 4'hF;
  localparam int         CLK_PERIOD_NS   = 40;
  localparam int         PUMP_IDLE_S     = 30;
  localparam int         PUMP_IDLE_CYC   = PUMP_IDLE_S * (1000000000 / CLK_PERIOD_NS);
  localparam int         PUMP_START_NS   = 45000;
  localparam int         PUMP_START_CYC  = (PUMP_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== tb/uart_sleep_checker.sv
// Port-level assertions for the APB, sleep, pump and loopback behaviour
`timescale 1ns/1ps
module uart_sleep_checker #(parameter int PUMP_IDLE_CYCLES = 200) (
  input wire logic        i_clk, i_reset_n, i_psel, i_penable, i_pwrite, i_pump_autosleep_pin,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready, o_pslverr, o_serial_out, o_request_to_send_out, o_terminal_ready_out,
  input wire logic        o_serial_out_oe, o_modem_out_oe, o_osc_run, o_pump_on, o_pump_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  logic loop_reg;
  logic sleep_en_reg;
  wire  wr_hit = i_psel && i_penable && o_pready && i_pwrite;
  // Shadows of the loopback and sleep enable bits as the host wrote them
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) loop_reg <= 1'h0;
    else if (wr_hit && i_paddr == uart_sleep_pkg::ADDR_MODEM_CTRL) loop_reg <= i_pwdata[4];
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) sleep_en_reg <= 1'h0;
    else if (wr_hit && i_paddr == uart_sleep_pkg::ADDR_INT_ENABLE) sleep_en_reg <= i_pwdata[4];
  sequence setup_s; i_psel && !i_penable; endsequence
  sequence unmapped_s; setup_s ##0 i_paddr > 8'h28; endsequence
  apb_answer_a: assert property (setup_s |=> o_pready ##1 !o_pready) else $error("pready not one cycle");
  apb_cause_a: assert property (o_pready |-> $past(i_psel) && i_penable) else $error("stray pready");
  apb_error_a: assert property (unmapped_s |=> o_pslverr && o_pready) else $error("unmapped accepted");
  loop_hold_a: assert property (loop_reg && $past(loop_reg) |->
    o_serial_out && o_request_to_send_out && o_terminal_ready_out) else $error("loopback outputs moved");
  wake_off_a: assert property (!sleep_en_reg [*4] |-> o_osc_run) else $error("asleep while disabled");
  pump_pin_a: assert property (!i_pump_autosleep_pin [*6] |-> o_pump_on) else $error("pump off, pin low");
  pump_start_a: assert property ($rose(o_pump_on) |=> !o_pump_ready [*8]) else $error("pump ready early");
  pump_ready_a: assert property (o_pump_ready |-> o_pump_on) else $error("ready with pump off");
  driver_off_a: assert property (!o_pump_on && !$past(o_pump_on) |->
    !o_serial_out_oe && !o_modem_out_oe) else $error("drivers on, pump off");
endmodule
bind uart_sleep_wake_loopback uart_sleep_checker #(.PUMP_IDLE_CYCLES(PUMP_IDLE_CYCLES)) uart_sleep_checker_inst (
  .i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_pump_autosleep_pin, .i_paddr, .i_pwdata,
  .o_pready, .o_pslverr, .o_serial_out, .o_request_to_send_out, .o_terminal_ready_out,
  .o_serial_out_oe, .o_modem_out_oe, .o_osc_run, .o_pump_on, .o_pump_ready);

// ===== tb/uart_remote_model.sv
// Remote serial equipment: frame sender at divisor 1 and modem pin driver
`timescale 1ns/1ps
module uart_remote_model (
  input  wire logic  i_clk,
  output logic       o_line,
  output logic [3:0] o_modem
);
  // Marking line and released modem pins from time zero
  initial begin
    o_line <= 1'h1;
    o_modem <= 4'hF;
  end
  // Start, n data bits LSB first, stop; line stays marking afterwards
  task automatic send(input logic [7:0] c, input int n);
    for (int i = -1; i <= n; i++) begin
      o_line <= (i < 0) ? 1'h0 : (i == n) ? 1'h1 : c[i];
      repeat (16) @(posedge i_clk);
    end
  endtask
  task automatic modem(input logic [3:0] v);
    o_modem <= v;
    @(posedge i_clk);
  endtask
endmodule

// ===== tb/uart_sleep_wake_loopback_tb_top.sv
// Bench: special character, loopback, sleep and charge pump scenarios
`timescale 1ns/1ps
module uart_sleep_wake_loopback_tb_top;
  logic        i_clk = 1'h0, i_reset_n, i_psel, i_penable, i_pwrite;
  logic        i_pump_autosleep_pin, o_pready, o_pslverr, o_serial_out, o_serial_out_oe, line, e;
  logic        o_request_to_send_out, o_terminal_ready_out, o_modem_out_oe, o_osc_run, o_pump_on, o_pump_ready;
  logic [7:0]  i_paddr, c;
  logic [31:0] i_pwdata, o_prdata, q;
  logic [3:0]  modem;
  int          n_errors = 0, tests_run = 0, cycles = 0, n;
  always #20 i_clk = ~i_clk;
  uart_remote_model uart_remote_model_inst (.i_clk, .o_line(line), .o_modem(modem));
  uart_sleep_wake_loopback #(.PUMP_IDLE_CYCLES(200)) uart_sleep_wake_loopback_inst (
    .i_clk, .i_reset_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_serial_in(line), .o_serial_out, .o_serial_out_oe, .i_clear_to_send_in(modem[3]), .i_set_ready_in(modem[2]),
    .i_line_presence_in(modem[1]), .i_bell_in(modem[0]), .o_request_to_send_out, .o_terminal_ready_out,
    .o_modem_out_oe, .i_pump_autosleep_pin, .o_osc_run, .o_pump_on, .o_pump_ready);
  task automatic conclude();
    if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge i_clk) if (++cycles == 10000) begin
    n_errors++;
    $display("unexpected %0t timeout", $time);
    conclude();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'h1;
    @(posedge i_clk);
    while (o_pready !== 1'h1) @(posedge i_clk);
    q = o_prdata;
    e = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(q & m, x);
  endtask
  // Received character as the host should read it for a given word length
  function automatic logic [31:0] char_exp(input logic [7:0] v, input int len);
    char_exp = {24'h00_0000, v} & ((32'h1 << len) - 32'h1);
  endfunction
  initial begin
    i_reset_n <= 1'h0;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    i_pwrite <= 1'h0;
    i_paddr <= 8'h00;
    i_pwdata <= 32'h0;
    i_pump_autosleep_pin <= 1'h0;
    void'($urandom(32'h77C0));
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'h1;
    rdc(uart_sleep_pkg::ADDR_DIV_LOW, 32'hFF, 32'h01);
    apb(1'h0, 8'hFC, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'h1, uart_sleep_pkg::ADDR_ENH_FEATURE, 32'h20);
    for (int l = 0; l < 4; l++) begin
      apb(1'h1, uart_sleep_pkg::ADDR_LINE_CTRL, l);
      for (int m = 0; m < 2; m++) begin
        c = $urandom;
        apb(1'h1, uart_sleep_pkg::ADDR_SPECIAL_CHAR, {24'h0, c});
        uart_remote_model_inst.send(c ^ m[7:0], 5 + l);
        repeat (4) @(posedge i_clk);
        rdc(uart_sleep_pkg::ADDR_INT_SOURCE, 32'h11, m ? 32'h01 : 32'h10);
        rdc(uart_sleep_pkg::ADDR_TX_HOLDING, 32'hFF, char_exp(c ^ m[7:0], 5 + l));
      end
    end
    apb(1'h1, uart_sleep_pkg::ADDR_MODEM_CTRL, 32'h13);
    apb(1'h0, uart_sleep_pkg::ADDR_MODEM_STATUS, 32'h0);
    uart_remote_model_inst.modem(4'h0);
    repeat (4) @(posedge i_clk);
    rdc(uart_sleep_pkg::ADDR_MODEM_STATUS, 32'hFF, 32'h30);
    c = $urandom;
    apb(1'h1, uart_sleep_pkg::ADDR_TX_HOLDING, {24'h0, c});
    repeat (200) @(posedge i_clk);
    rdc(uart_sleep_pkg::ADDR_TX_HOLDING, 32'hFF, {24'h0, c});
    apb(1'h0, uart_sleep_pkg::ADDR_INT_SOURCE, 32'h0);
    uart_remote_model_inst.modem(4'hF);
    apb(1'h1, uart_sleep_pkg::ADDR_MODEM_CTRL, 32'h0);
    apb(1'h0, uart_sleep_pkg::ADDR_MODEM_STATUS, 32'h0);
    apb(1'h1, uart_sleep_pkg::ADDR_DIV_LOW, 32'h0);
    apb(1'h1, uart_sleep_pkg::ADDR_INT_ENABLE, 32'h10);
    repeat (6) @(posedge i_clk);
    chk(o_osc_run, 1'h1);
    apb(1'h1, uart_sleep_pkg::ADDR_DIV_LOW, 32'h1);
    repeat (6) @(posedge i_clk);
    chk(o_osc_run, 1'h0);
    uart_remote_model_inst.modem(4'h7);
    repeat (10) @(posedge i_clk);
    chk(o_osc_run, 1'h1);
    apb(1'h0, uart_sleep_pkg::ADDR_MODEM_STATUS, 32'h0);
    repeat (6) @(posedge i_clk);
    chk(o_osc_run, 1'h0);
    apb(1'h1, uart_sleep_pkg::ADDR_TX_HOLDING, 32'h55);
    repeat (2) @(posedge i_clk);
    chk(o_osc_run, 1'h1);
    repeat (200) @(posedge i_clk);
    chk(o_osc_run, 1'h0);
    i_pump_autosleep_pin <= 1'h1;
    repeat (8) @(posedge i_clk);
    chk({o_pump_on, o_serial_out_oe}, 32'h0);
    rdc(uart_sleep_pkg::ADDR_LINE_CTRL, 32'hFF, 32'h03);
    i_pump_autosleep_pin <= 1'h0;
    for (n = 0; o_pump_ready !== 1'h1; n++) @(posedge i_clk);
    chk(n >= 1125 && n <= 1132, 1'h1);
    apb(1'h1, uart_sleep_pkg::ADDR_INT_ENABLE, 32'h0);
    uart_remote_model_inst.modem(4'h0);
    i_pump_autosleep_pin <= 1'h1;
    repeat (260) @(posedge i_clk);
    chk(o_pump_on, 1'h0);
    uart_remote_model_inst.modem(4'h8);
    repeat (6) @(posedge i_clk);
    chk(o_pump_on, 1'h1);
    conclude();
  end
endmodule
